// [logic/rpm_pkg.sv]
// package of constants and types for the radio power mode controller
package rpm_pkg;
	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam logic [11:0] RPM_ADDR_MODE = 12'h000;
	localparam logic [11:0] RPM_ADDR_STAT = 12'h004;
	localparam logic [11:0] RPM_ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] RPM_ADDR_IRQ_MASK = 12'h00c;
	localparam logic [3:0] RPM_MODE_RESET = 4'h0;
	localparam int RPM_STAT_READY_BIT = 0;
	localparam int RPM_STAT_BROWN_BIT = 1;
	localparam int RPM_IRQ_W = 3;
	localparam int RPM_IRQ_READY_BIT = 0;
	localparam int RPM_IRQ_BROWN_BIT = 1;
	localparam int RPM_IRQ_MODE_BIT = 2;
	// --------------------------------------------------------------
	// mode codes
	// --------------------------------------------------------------
	localparam logic [3:0] RPM_CODE_RETAIN = 4'h0;
	localparam logic [3:0] RPM_CODE_OFF = 4'h1;
	localparam logic [3:0] RPM_CODE_STANDBY = 4'h5;
	localparam logic [3:0] RPM_CODE_FIFO = 4'h6;
	localparam logic [3:0] RPM_CODE_RX_SETTLE = 4'h8;
	localparam logic [3:0] RPM_CODE_RX = 4'h9;
	localparam logic [3:0] RPM_CODE_WOR = 4'hb;
	localparam logic [3:0] RPM_CODE_TX_SETTLE = 4'hc;
	localparam logic [3:0] RPM_CODE_TX = 4'hd;
	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int RPM_CLK_MHZ = 100;
	localparam int RPM_REG_SETTLE_NS = 1000;
	localparam int RPM_REG_SETTLE_CYC = (RPM_REG_SETTLE_NS * RPM_CLK_MHZ + 999) / 1000;
	localparam int RPM_WAKE_INIT_NS = 2000;
	localparam int RPM_WAKE_INIT_CYC = (RPM_WAKE_INIT_NS * RPM_CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {RPM_ST_IDLE, RPM_ST_WAIT_FIFO, RPM_ST_SETTLE} rpm_seq_t;

	function automatic logic rpm_code_legal(input logic [3:0] c);
		return c == RPM_CODE_RETAIN || c == RPM_CODE_OFF || c == RPM_CODE_STANDBY ||
			c == RPM_CODE_FIFO || c == RPM_CODE_RX_SETTLE || c == RPM_CODE_RX ||
			c == RPM_CODE_WOR || c == RPM_CODE_TX_SETTLE || c == RPM_CODE_TX;
	endfunction : rpm_code_legal

	function automatic logic rpm_needs_fifo_empty(input logic [3:0] c);
		return c == RPM_CODE_RETAIN || c == RPM_CODE_STANDBY || c == RPM_CODE_WOR;
	endfunction : rpm_needs_fifo_empty
endpackage : rpm_pkg

// [logic/rpm_mode_decode.sv]
// decoder from power state code to supply and block enables
`timescale 1ns/100ps
`default_nettype none
module rpm_mode_decode
	import rpm_pkg::*;
(
	input wire logic [3:0] code,
	output logic core_supply_en,
	output logic xtal_en,
	output logic ref_en,
	output logic synth_en,
	output logic synth_tx_freq,
	output logic rx_en,
	output logic tx_en,
	output logic lpo_en,
	output logic fifo_access_en
);
	always_comb begin
		core_supply_en = 1'b1;
		xtal_en = 1'b1;
		ref_en = 1'b1;
		synth_en = 1'b0;
		synth_tx_freq = 1'b0;
		rx_en = 1'b0;
		tx_en = 1'b0;
		lpo_en = 1'b0;
		fifo_access_en = 1'b1;
		unique case (code)
			RPM_CODE_RETAIN, RPM_CODE_WOR, RPM_CODE_OFF: begin
				core_supply_en = 1'b0;
				xtal_en = 1'b0;
				ref_en = 1'b0;
				fifo_access_en = 1'b0;
				lpo_en = (code == RPM_CODE_WOR);
			end
			RPM_CODE_STANDBY: fifo_access_en = 1'b0;
			RPM_CODE_FIFO: xtal_en = 1'b0;
			RPM_CODE_RX_SETTLE: synth_en = 1'b1;
			RPM_CODE_RX: begin
				synth_en = 1'b1;
				rx_en = 1'b1;
			end
			RPM_CODE_TX_SETTLE: begin
				synth_en = 1'b1;
				synth_tx_freq = 1'b1;
			end
			RPM_CODE_TX: begin
				synth_en = 1'b1;
				synth_tx_freq = 1'b1;
				tx_en = 1'b1;
			end
			default: begin
				core_supply_en = 1'b0;
				xtal_en = 1'b0;
				ref_en = 1'b0;
				fifo_access_en = 1'b0;
			end
		endcase
	end
endmodule : rpm_mode_decode
`default_nettype wire

// [logic/rpm_settle_timer.sv]
// down counter timing regulator settling and wake initialisation
`timescale 1ns/100ps
`default_nettype none
module rpm_settle_timer #(
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [W-1:0] count,
	output logic busy
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if (start) begin
			cnt_r <= count;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign busy = start || (cnt_r != '0);
endmodule : rpm_settle_timer
`default_nettype wire

// [logic/rpm_ctrl.sv]
// radio power mode controller with apb registers and interrupt
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rpm_ctrl
	import rpm_pkg::*;
#(
	parameter int REG_SETTLE_CYC = RPM_REG_SETTLE_CYC,
	parameter int WAKE_INIT_CYC = RPM_WAKE_INIT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fifo_empty,
	input wire logic io_brownout,
	input wire logic wake_strobe_n,
	output logic fifo_flush,
	output logic data_out_ready,
	output logic core_supply_en,
	output logic xtal_en,
	output logic ref_en,
	output logic synth_en,
	output logic synth_tx_freq,
	output logic rx_en,
	output logic tx_en,
	output logic lpo_en,
	output logic fifo_access_en,
	output logic irq
);
	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [3:0] req_code_r;
	logic [3:0] active_code_r;
	rpm_seq_t seq_r;
	logic [RPM_IRQ_W-1:0] irq_stat_r;
	logic [RPM_IRQ_W-1:0] irq_mask_r;
	logic ready_r;
	logic ready_q_r;
	logic brown_q_r;
	logic waking_r;
	logic [31:0] prdata_r;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic mode_wr;
	logic apply;
	logic timer_start;
	logic timer_busy;
	logic [15:0] timer_count;
	logic in_off;
	logic wake_evt;
	logic [RPM_IRQ_W-1:0] irq_set;
	logic [3:0] dec_code;

	// --------------------------------------------------------------
	// apb decode
	// --------------------------------------------------------------
	assign addr_ok = paddr == RPM_ADDR_MODE || paddr == RPM_ADDR_STAT ||
		paddr == RPM_ADDR_IRQ_STAT || paddr == RPM_ADDR_IRQ_MASK;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	// bus writes are ignored while the transceiver sleeps in full-off; reads still answer
	assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0] && !in_off;
	assign rd_en = psel && !penable && !pwrite;
	assign mode_wr = wr_en && paddr == RPM_ADDR_MODE;
	assign in_off = active_code_r == RPM_CODE_OFF;
	assign wake_evt = in_off && !wake_strobe_n;

	// --------------------------------------------------------------
	// mode request register
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_code_r <= RPM_MODE_RESET;
		end else if (wake_evt) begin
			req_code_r <= RPM_MODE_RESET;
		end else if (mode_wr && rpm_code_legal(pwdata[3:0])) begin
			req_code_r <= pwdata[3:0];
		end
	end

	// --------------------------------------------------------------
	// sequencer: wait for empty fifo before RETAIN, STANDBY or WOR, then apply code and settle supplies
	// --------------------------------------------------------------
	assign apply = (seq_r == RPM_ST_IDLE && req_code_r != active_code_r &&
		!rpm_needs_fifo_empty(req_code_r)) ||
		(seq_r == RPM_ST_WAIT_FIFO && fifo_empty);
	assign timer_start = apply || wake_evt;
	assign timer_count = wake_evt ? 16'(WAKE_INIT_CYC) : 16'(REG_SETTLE_CYC);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_r <= RPM_ST_IDLE;
		end else begin
			unique case (seq_r)
				RPM_ST_IDLE: begin
					if (apply) begin
						seq_r <= RPM_ST_SETTLE;
					end else if (req_code_r != active_code_r) begin
						seq_r <= RPM_ST_WAIT_FIFO;
					end
				end
				RPM_ST_WAIT_FIFO: begin
					if (fifo_empty) begin
						seq_r <= RPM_ST_SETTLE;
					end
				end
				RPM_ST_SETTLE: begin
					if (!timer_busy) begin
						seq_r <= RPM_ST_IDLE;
					end
				end
				default: seq_r <= RPM_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_code_r <= RPM_MODE_RESET;
		end else if (wake_evt) begin
			active_code_r <= RPM_MODE_RESET;
		end else if (apply) begin
			active_code_r <= req_code_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waking_r <= 1'b0;
		end else if (wake_evt) begin
			waking_r <= 1'b1;
		end else if (!timer_busy) begin
			waking_r <= 1'b0;
		end
	end

	// data-out low in full-off and during wake init, high once the wake timer runs out
	assign data_out_ready = !waking_r && !in_off;

	rpm_settle_timer #(
		.W(16)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(timer_start),
		.count(timer_count),
		.busy(timer_busy)
	);

	// --------------------------------------------------------------
	// supply enables follow the applied code
	// --------------------------------------------------------------
	assign dec_code = active_code_r;

	rpm_mode_decode u_dec (
		.code(dec_code),
		.core_supply_en(core_supply_en),
		.xtal_en(xtal_en),
		.ref_en(ref_en),
		.synth_en(synth_en),
		.synth_tx_freq(synth_tx_freq),
		.rx_en(rx_en),
		.tx_en(tx_en),
		.lpo_en(lpo_en),
		.fifo_access_en(fifo_access_en)
	);

	// fifo contents discarded whenever access is removed
	assign fifo_flush = !fifo_access_en;

	// --------------------------------------------------------------
	// status
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= !timer_busy && seq_r != RPM_ST_SETTLE && core_supply_en;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q_r <= 1'b0;
			brown_q_r <= 1'b0;
		end else begin
			ready_q_r <= ready_r;
			brown_q_r <= io_brownout;
		end
	end

	// --------------------------------------------------------------
	// interrupts: set wins over write-one-to-clear
	// --------------------------------------------------------------
	always_comb begin
		irq_set = '0;
		irq_set[RPM_IRQ_READY_BIT] = ready_r && !ready_q_r;
		irq_set[RPM_IRQ_BROWN_BIT] = io_brownout && !brown_q_r;
		irq_set[RPM_IRQ_MODE_BIT] = apply;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= '0;
		end else if (wake_evt) begin
			irq_stat_r <= irq_set;
		end else if (wr_en && paddr == RPM_ADDR_IRQ_STAT) begin
			irq_stat_r <= (irq_stat_r & ~pwdata[RPM_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_r <= irq_stat_r | irq_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= '0;
		end else if (wake_evt) begin
			irq_mask_r <= '0;
		end else if (wr_en && paddr == RPM_ADDR_IRQ_MASK) begin
			irq_mask_r <= pwdata[RPM_IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// --------------------------------------------------------------
	// read data, captured in the setup phase
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
		end else if (rd_en) begin
			prdata_r <= '0;
			unique case (paddr)
				RPM_ADDR_MODE: prdata_r[3:0] <= req_code_r;
				RPM_ADDR_STAT: begin
					prdata_r[RPM_STAT_READY_BIT] <= ready_r;
					prdata_r[RPM_STAT_BROWN_BIT] <= io_brownout;
				end
				RPM_ADDR_IRQ_STAT: prdata_r[RPM_IRQ_W-1:0] <= irq_stat_r;
				RPM_ADDR_IRQ_MASK: prdata_r[RPM_IRQ_W-1:0] <= irq_mask_r;
				default: prdata_r <= '0;
			endcase
		end
	end

	assign prdata = prdata_r;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	property p_tx_has_synth;
		@(posedge pclk) disable iff (!presetn) tx_en |-> synth_en && synth_tx_freq && !rx_en;
	endproperty
	a_tx_has_synth: assert property (p_tx_has_synth) else $error("tx without synth");

	property p_rx_settle;
		@(posedge pclk) disable iff (!presetn)
			active_code_r == RPM_CODE_RX_SETTLE |-> synth_en && !rx_en && !tx_en && !synth_tx_freq;
	endproperty
	a_rx_settle: assert property (p_rx_settle) else $error("rx settle wrong");

	property p_rx_full;
		@(posedge pclk) disable iff (!presetn) active_code_r == RPM_CODE_RX |-> synth_en && rx_en;
	endproperty
	a_rx_full: assert property (p_rx_full) else $error("rx full wrong");

	property p_wor;
		@(posedge pclk) disable iff (!presetn)
			active_code_r == RPM_CODE_WOR |-> lpo_en && !core_supply_en && fifo_flush;
	endproperty
	a_wor: assert property (p_wor) else $error("wor wrong");

	property p_tx_settle;
		@(posedge pclk) disable iff (!presetn)
			active_code_r == RPM_CODE_TX_SETTLE |-> synth_tx_freq && !tx_en && !rx_en;
	endproperty
	a_tx_settle: assert property (p_tx_settle) else $error("tx settle wrong");

	property p_fifo_gate;
		@(posedge pclk) disable iff (!presetn)
			$changed(active_code_r) && rpm_needs_fifo_empty(active_code_r) |-> $past(fifo_empty);
	endproperty
	a_fifo_gate: assert property (p_fifo_gate) else $error("entered without empty fifo");

	property p_bad_code;
		@(posedge pclk) disable iff (!presetn)
			mode_wr && !rpm_code_legal(pwdata[3:0]) && !wake_evt |=> $stable(req_code_r);
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("illegal code taken");

	sequence s_change;
		apply;
	endsequence
	property p_ready_drop;
		@(posedge pclk) disable iff (!presetn) s_change |=> ##1 !ready_r;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready during change");

	property p_fifo_mode;
		@(posedge pclk) disable iff (!presetn)
			active_code_r == RPM_CODE_FIFO |-> fifo_access_en && ref_en && !fifo_flush;
	endproperty
	a_fifo_mode: assert property (p_fifo_mode) else $error("fifo mode wrong");

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
			wake_evt |=> !data_out_ready && active_code_r == RPM_CODE_RETAIN;
	endproperty
	a_wake: assert property (p_wake) else $error("wake wrong");

	property p_retain;
		@(posedge pclk) disable iff (!presetn)
			active_code_r == RPM_CODE_RETAIN |-> !core_supply_en && !lpo_en && fifo_flush;
	endproperty
	a_retain: assert property (p_retain) else $error("retention wrong");

	property p_standby;
		@(posedge pclk) disable iff (!presetn)
			active_code_r == RPM_CODE_STANDBY |-> xtal_en && ref_en && !rx_en && !tx_en &&
			fifo_flush;
	endproperty
	a_standby: assert property (p_standby) else $error("standby wrong");

	property p_full_off;
		@(posedge pclk) disable iff (!presetn)
			in_off |-> !core_supply_en && !xtal_en && !ref_en && !synth_en && !lpo_en &&
			!fifo_access_en && !data_out_ready;
	endproperty
	a_full_off: assert property (p_full_off) else $error("full-off wrong");

	property p_ready_valid;
		@(posedge pclk) disable iff (!presetn)
			ready_r |-> core_supply_en && seq_r != RPM_ST_SETTLE;
	endproperty
	a_ready_valid: assert property (p_ready_valid) else $error("ready while settling");
endmodule : rpm_ctrl
`default_nettype wire

// [verif/rpm_front_model.sv]
// front end model: fifo drain, brown-out comparator, debug wake pin
`timescale 1ns/100ps
`default_nettype none
module rpm_front_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fifo_flush,
	input wire logic [7:0] fill,
	input wire logic fill_go,
	input wire logic brown,
	input wire logic wake_go,
	output logic fifo_empty,
	output logic io_brownout,
	output logic wake_strobe_n
);
	// ----------------------------------------------------------
	// fifo level, drained one word a cycle by the radio side
	// ----------------------------------------------------------
	logic [7:0] level_r;
	// flush beats a fill in the same cycle, as the real store is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r <= 8'h00;
		end else if (fifo_flush) begin
			level_r <= 8'h00;
		end else if (fill_go) begin
			level_r <= fill;
		end else if (level_r != 8'h00) begin
			level_r <= level_r - 8'h01;
		end
	end
	assign fifo_empty = (level_r == 8'h00);
	assign io_brownout = brown;
	// ----------------------------------------------------------
	// wake pin: pulled up whenever the adapter lets go
	// ----------------------------------------------------------
	assign wake_strobe_n = !wake_go;
endmodule : rpm_front_model
`default_nettype wire

// [verif/rpm_ctrl_tb.sv]
// self-checking bench for the radio power mode controller
`timescale 1ns/100ps
`default_nettype none
module rpm_ctrl_tb import rpm_pkg::*;;
	localparam int SETTLE = 4;
	localparam int WAKE = 8;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, fifo_empty, io_brownout, wake_strobe_n, fifo_flush, data_out_ready;
	logic core_supply_en, xtal_en, ref_en, synth_en, synth_tx_freq, rx_en, tx_en, lpo_en;
	logic fifo_access_en, irq;
	logic [7:0] fill = 8'h00;
	logic fill_go = 1'b0;
	logic brown = 1'b0;
	logic wake_go = 1'b0;
	logic [32:0] expq[$];
	logic [32:0] note;
	integer seed = 67;
	int fail_count = 0;
	int checked = 0;
	int tests = 0;
	always #5 pclk = ~pclk;
	rpm_ctrl #(.REG_SETTLE_CYC(SETTLE), .WAKE_INIT_CYC(WAKE)) DUT (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .fifo_empty,
		.io_brownout, .wake_strobe_n, .fifo_flush, .data_out_ready, .core_supply_en, .xtal_en,
		.ref_en, .synth_en, .synth_tx_freq, .rx_en, .tx_en, .lpo_en, .fifo_access_en, .irq);
	rpm_front_model FE (.pclk, .presetn, .fifo_flush, .fill, .fill_go, .brown, .wake_go,
		.fifo_empty, .io_brownout, .wake_strobe_n);
	// ----------------------------------------------------------
	// reporting
	// ----------------------------------------------------------
	task automatic wrap_up();
		$display("tests %0d checks %0d mismatches %0d", tests, checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic done(input string s);
		tests++;
		$display("test %s done", s);
	endtask : done
	// ----------------------------------------------------------
	// apb master; read notes go to the queue, the monitor compares
	// ----------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= {3'($random(seed)), 1'b1};
		if (!w) expq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			wrap_up();
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [3:0] v);
		apb(1'b1, a, {28'($random(seed)), v}, 33'h0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic err);
		apb(1'b0, a, 32'h0, {err, v});
	endtask : rd
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			note = expq.pop_front();
			chk({pslverr, prdata}, note);
		end
	end
	// mode change: ready drops, comes back unless RETAIN or WOR, then the enables match
	task automatic go(input logic [3:0] c, input logic [3:0] v);
		wr(RPM_ADDR_MODE, c);
		repeat (2) @(posedge pclk);
		rd(RPM_ADDR_STAT, 32'h0, 1'b0);
		repeat (SETTLE + 8) @(posedge pclk);
		rd(RPM_ADDR_STAT, {31'h0, c != RPM_CODE_RETAIN && c != RPM_CODE_WOR}, 1'b0);
		rd(RPM_ADDR_MODE, {28'h0, c}, 1'b0);
		@(negedge pclk);
		chk({29'h0, synth_en, rx_en, tx_en, lpo_en}, {29'h0, v});
	endtask : go
	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	logic [7:0] seq[10] = '{8'h50, 8'h88, 8'h9c, 8'h00, 8'h50, 8'hc8, 8'hda, 8'h60, 8'hb1, 8'h00};
	logic [3:0] wt[2] = '{RPM_CODE_RETAIN, RPM_CODE_STANDBY};
	initial begin
		int n;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(RPM_ADDR_MODE, 32'h0, 1'b0);
		@(negedge pclk);
		chk({31'h0, fifo_flush, irq}, 33'h2);
		done("reset");
		for (int i = 0; i < 10; i++) begin
			go(seq[i][7:4], seq[i][3:0]);
			if (seq[i][7]) chk({32'h0, synth_tx_freq}, {32'h0, seq[i][6]});
			if (seq[i][7:4] == RPM_CODE_STANDBY) chk({31'h0, xtal_en, ref_en}, 33'h3);
			if (seq[i][7:4] == RPM_CODE_FIFO)
				chk({30'h0, ref_en, fifo_access_en, fifo_flush}, 33'h6);
			if (seq[i][7:4] == RPM_CODE_RETAIN || seq[i][7:4] == RPM_CODE_WOR)
				chk({30'h0, core_supply_en, fifo_access_en, fifo_flush}, 33'h1);
		end
		wr(RPM_ADDR_MODE, 4'h3);
		rd(RPM_ADDR_MODE, 32'h0, 1'b0);
		done("session");
		for (int i = 0; i < 2; i++) begin
			go(RPM_CODE_FIFO, 4'h0);
			@(posedge pclk);
			fill <= 8'd20;
			fill_go <= 1'b1;
			@(posedge pclk);
			fill_go <= 1'b0;
			wr(RPM_ADDR_MODE, wt[i]);
			repeat (3) @(negedge pclk);
			chk({31'h0, fifo_access_en, fifo_flush}, 33'h2);
			n = 0;
			while (fifo_flush !== 1'b1 && n < 60) begin
				@(negedge pclk);
				n++;
			end
			if (n >= 60) begin
				fail_count++;
				wrap_up();
			end
			chk({31'h0, fifo_empty, (n > 10)}, 33'h3);
		end
		done("fifo wait");
		wr(RPM_ADDR_IRQ_STAT, 4'h7);
		wr(RPM_ADDR_IRQ_MASK, 4'h4);
		go(RPM_CODE_FIFO, 4'h0);
		chk({32'h0, irq}, 33'h1);
		rd(RPM_ADDR_IRQ_STAT, 32'h5, 1'b0);
		wr(RPM_ADDR_IRQ_STAT, 4'h7);
		wr(RPM_ADDR_IRQ_MASK, 4'h2);
		@(negedge pclk);
		chk({32'h0, irq}, 33'h0);
		@(posedge pclk);
		brown <= 1'b1;
		repeat (3) @(negedge pclk);
		chk({32'h0, irq}, 33'h1);
		rd(RPM_ADDR_STAT, 32'h3, 1'b0);
		rd(RPM_ADDR_IRQ_STAT, 32'h2, 1'b0);
		wr(RPM_ADDR_IRQ_MASK, 4'h0);
		@(negedge pclk);
		chk({32'h0, irq}, 33'h0);
		wr(RPM_ADDR_IRQ_STAT, 4'h2);
		rd(RPM_ADDR_IRQ_STAT, 32'h0, 1'b0);
		brown <= 1'b0;
		rd(12'h010, 32'h0, 1'b1);
		done("irq");
		wr(RPM_ADDR_IRQ_MASK, 4'h4);
		wr(RPM_ADDR_MODE, RPM_CODE_OFF);
		repeat (3) @(negedge pclk);
		chk({25'h0, core_supply_en, xtal_en, ref_en, synth_en, rx_en, tx_en, lpo_en,
			data_out_ready}, 33'h0);
		wr(RPM_ADDR_MODE, RPM_CODE_STANDBY);
		rd(RPM_ADDR_MODE, 32'h1, 1'b0);
		@(posedge pclk);
		wake_go <= 1'b1;
		repeat (2) @(posedge pclk);
		wake_go <= 1'b0;
		@(negedge pclk);
		chk({32'h0, data_out_ready}, 33'h0);
		n = 0;
		while (data_out_ready !== 1'b1 && n < WAKE + 20) begin
			@(negedge pclk);
			n++;
		end
		if (n >= WAKE + 20) begin
			fail_count++;
			wrap_up();
		end
		chk({32'h0, (n >= WAKE - 3)}, 33'h1);
		rd(RPM_ADDR_MODE, 32'h0, 1'b0);
		rd(RPM_ADDR_IRQ_MASK, 32'h0, 1'b0);
		rd(RPM_ADDR_IRQ_STAT, 32'h0, 1'b0);
		done("full off");
		go(RPM_CODE_STANDBY, 4'h0);
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk({31'h0, fifo_flush, xtal_en}, 33'h2);
		@(posedge pclk);
		presetn <= 1'b1;
		rd(RPM_ADDR_MODE, 32'h0, 1'b0);
		done("second reset");
		wrap_up();
	end
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end
endmodule : rpm_ctrl_tb
`default_nettype wire
